// file: sdbl_pkg.sv
// shared constants and types for the bank command legality block
package sdbl_pkg;

    localparam int CLK_PERIOD_NS        = 20;
    localparam int PRECHARGE_PERIOD_NS  = 20;
    localparam int ACT_TO_ACCESS_NS     = 20;
    localparam int REFRESH_CYCLE_NS     = 70;
    localparam int SELF_REF_EXIT_NS     = 70;
    localparam int MODE_LOAD_CYC        = 2;
    localparam int BURST_LEN_DEF        = 4;

    // least times round up to whole cycles, never below one
    localparam int PRECHARGE_PERIOD_CYC = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACT_TO_ACCESS_CYC    = (ACT_TO_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFRESH_CYCLE_CYC    = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELF_REF_EXIT_CYC    = (SELF_REF_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int NUM_BANKS            = 4;
    localparam int TMR_W                = 8;
    localparam int PIN_W                = 8;
    localparam logic [7:0] PIN_RST      = 8'h7E;

    typedef enum logic [3:0] {
        CMD_INHIBIT = 4'h0,
        CMD_NOP     = 4'h1,
        CMD_ACT     = 4'h2,
        CMD_RD      = 4'h3,
        CMD_WR      = 4'h4,
        CMD_PRE     = 4'h5,
        CMD_REF     = 4'h6,
        CMD_MRS     = 4'h7,
        CMD_BST     = 4'h8
    } sdbl_cmd_t;

    typedef enum logic [7:0] {
        BK_IDLE  = 8'h01,
        BK_ACTG  = 8'h02,
        BK_ACTV  = 8'h04,
        BK_RD    = 8'h08,
        BK_WR    = 8'h10,
        BK_PRE   = 8'h20,
        BK_RDAP  = 8'h40,
        BK_WRAP  = 8'h80
    } sdbl_bank_st_t;

    typedef enum logic [4:0] {
        G_NORM = 5'h01,
        G_REF  = 5'h02,
        G_MRS  = 5'h04,
        G_SREF = 5'h08,
        G_SXIT = 5'h10
    } sdbl_glob_st_t;

endpackage : sdbl_pkg

// file: sdbl_bank_if.sv
// command and state carrier between the decoder and one bank tracker
interface sdbl_bank_if;
    logic                   cmd_go;
    sdbl_pkg::sdbl_cmd_t    cmd;
    logic                   ap;
    logic                   stop;
    logic                   cut;
    sdbl_pkg::sdbl_bank_st_t st;
    logic                   same_ok;

    modport ctrl (output cmd_go, cmd, ap, stop, cut, input st, same_ok);
    modport bank (input cmd_go, cmd, ap, stop, cut, output st, same_ok);
endinterface : sdbl_bank_if

// file: sdbl_bank.sv
// per-bank state tracker with its own delay timer
module sdbl_bank #(
    parameter int BURST_LEN = sdbl_pkg::BURST_LEN_DEF
) (
    input  wire logic  clk_i,
    input  wire logic  sys_rst_i,
    sdbl_bank_if.bank  bif
);
    localparam logic [sdbl_pkg::TMR_W-1:0] PRE_T = sdbl_pkg::TMR_W'(sdbl_pkg::PRECHARGE_PERIOD_CYC);
    localparam logic [sdbl_pkg::TMR_W-1:0] ACT_T = sdbl_pkg::TMR_W'(sdbl_pkg::ACT_TO_ACCESS_CYC);
    localparam logic [sdbl_pkg::TMR_W-1:0] BL_T  = sdbl_pkg::TMR_W'(BURST_LEN);

    sdbl_pkg::sdbl_bank_st_t        st_r;
    sdbl_pkg::sdbl_bank_st_t        st_nxt;
    logic [sdbl_pkg::TMR_W-1:0]     tmr_r;
    logic [sdbl_pkg::TMR_W-1:0]     tmr_nxt;
    wire                            done;
    wire                            in_burst;

    assign done     = (tmr_r == sdbl_pkg::TMR_W'(1));
    assign in_burst = (st_r == sdbl_pkg::BK_RD) || (st_r == sdbl_pkg::BK_WR);
    assign bif.st   = st_r;

    // same-bank command acceptance per state
    always_comb begin
        unique case (st_r)
            sdbl_pkg::BK_IDLE: bif.same_ok = (bif.cmd == sdbl_pkg::CMD_ACT) || (bif.cmd == sdbl_pkg::CMD_PRE);
            sdbl_pkg::BK_ACTV: bif.same_ok = (bif.cmd == sdbl_pkg::CMD_RD) || (bif.cmd == sdbl_pkg::CMD_WR)
                                           || (bif.cmd == sdbl_pkg::CMD_PRE);
            sdbl_pkg::BK_RD,
            sdbl_pkg::BK_WR:   bif.same_ok = (bif.cmd == sdbl_pkg::CMD_RD) || (bif.cmd == sdbl_pkg::CMD_WR)
                                           || (bif.cmd == sdbl_pkg::CMD_PRE) || (bif.cmd == sdbl_pkg::CMD_BST);
            default:           bif.same_ok = 1'b0;
        endcase
    end

    always_comb begin
        st_nxt  = st_r;
        tmr_nxt = (tmr_r > sdbl_pkg::TMR_W'(1)) ? tmr_r - sdbl_pkg::TMR_W'(1) : tmr_r;
        if (bif.cmd_go) begin
            unique case (bif.cmd)
                sdbl_pkg::CMD_ACT: begin
                    st_nxt  = sdbl_pkg::BK_ACTG;
                    tmr_nxt = ACT_T;
                end
                sdbl_pkg::CMD_RD: begin
                    st_nxt  = bif.ap ? sdbl_pkg::BK_RDAP : sdbl_pkg::BK_RD;
                    tmr_nxt = BL_T;
                end
                sdbl_pkg::CMD_WR: begin
                    st_nxt  = bif.ap ? sdbl_pkg::BK_WRAP : sdbl_pkg::BK_WR;
                    tmr_nxt = BL_T;
                end
                sdbl_pkg::CMD_PRE: begin
                    if (st_r != sdbl_pkg::BK_IDLE) begin
                        st_nxt  = sdbl_pkg::BK_PRE;
                        tmr_nxt = PRE_T;
                    end
                end
                default: begin
                    st_nxt = st_r;
                end
            endcase
        end else if (bif.stop && in_burst) begin
            st_nxt = sdbl_pkg::BK_ACTV;
        end else if (bif.cut && in_burst) begin
            st_nxt = sdbl_pkg::BK_ACTV;
        end else if (bif.cut && (st_r == sdbl_pkg::BK_RDAP || st_r == sdbl_pkg::BK_WRAP)) begin
            st_nxt  = sdbl_pkg::BK_PRE;
            tmr_nxt = PRE_T;
        end else if (done) begin
            unique case (st_r)
                sdbl_pkg::BK_ACTG: st_nxt = sdbl_pkg::BK_ACTV;
                sdbl_pkg::BK_RD,
                sdbl_pkg::BK_WR:   st_nxt = sdbl_pkg::BK_ACTV;
                sdbl_pkg::BK_PRE:  st_nxt = sdbl_pkg::BK_IDLE;
                sdbl_pkg::BK_RDAP,
                sdbl_pkg::BK_WRAP: begin
                    st_nxt  = sdbl_pkg::BK_PRE;
                    tmr_nxt = PRE_T;
                end
                default:           st_nxt = st_r;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_r  <= sdbl_pkg::BK_IDLE;
            tmr_r <= '0;
        end else begin
            st_r  <= st_nxt;
            tmr_r <= tmr_nxt;
        end
    end
endmodule : sdbl_bank

// file: sdbl_top.sv
// command decoder, global state and four bank trackers
//
// Summary of operation
// - judge commands only with clock enable held high; self refresh entry is judged as it falls
// - decode strobes into inhibit, nop and commands
// - each bank keeps and judges its own state
// - idle bank takes activate; precharge is no-op
// - active bank takes read, write, precharge
// - burst state lasts until done, terminated or cut
// - reading bank takes read, write, precharge, terminate
// - writing bank takes read, write, precharge, terminate
// - precharging lasts one precharge period, then idle
// - activating lasts access delay, then row active
// - read with autoclose returns idle by itself
// - write with autoclose returns idle by itself
// - refresh holds busy for refresh period, then idle
// - mode load holds busy for its delay
// - burst terminate stops the latest burst only
// - idle bank never blocks other banks
// - busy bank allows other banks their commands
// - unlisted combinations are refused and flagged
// - interrupted autoclose burst starts closing at once
module sdbl_top #(
    parameter int BURST_LEN = sdbl_pkg::BURST_LEN_DEF
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        cke_i,
    input  wire logic        cs_n_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [1:0]  bank_i,
    input  wire logic        a10_i,
    output logic [31:0]      bank_state_o,
    output logic             all_idle_o,
    output logic             busy_o,
    output logic             self_refresh_o,
    output logic             accept_o,
    output logic             illegal_o,
    output logic [3:0]       cmd_o
);
    generate
        if (BURST_LEN < 1 || BURST_LEN > 255) begin : g_chk
            $error("BURST_LEN must lie in 1..255");
        end

        if (sdbl_pkg::REFRESH_CYCLE_CYC > 255 || sdbl_pkg::SELF_REF_EXIT_CYC > 255
            || sdbl_pkg::MODE_LOAD_CYC > 255 || sdbl_pkg::ACT_TO_ACCESS_CYC > 255
            || sdbl_pkg::PRECHARGE_PERIOD_CYC > 255) begin : g_tmr_chk
            $error("package delays must fit the timer");
        end
    endgenerate

    localparam logic [sdbl_pkg::TMR_W-1:0] REF_T  = sdbl_pkg::TMR_W'(sdbl_pkg::REFRESH_CYCLE_CYC);
    localparam logic [sdbl_pkg::TMR_W-1:0] MRS_T  = sdbl_pkg::TMR_W'(sdbl_pkg::MODE_LOAD_CYC);
    localparam logic [sdbl_pkg::TMR_W-1:0] SXIT_T = sdbl_pkg::TMR_W'(sdbl_pkg::SELF_REF_EXIT_CYC);

    // command strobes to command code
    function automatic sdbl_pkg::sdbl_cmd_t sdbl_decode(input logic cs_n, input logic ras_n,
                                                       input logic cas_n, input logic we_n);
        logic [2:0] s;
        s = {ras_n, cas_n, we_n};
        if (cs_n) begin
            return sdbl_pkg::CMD_INHIBIT;
        end
        unique case (s)
            3'b111:  return sdbl_pkg::CMD_NOP;
            3'b011:  return sdbl_pkg::CMD_ACT;
            3'b101:  return sdbl_pkg::CMD_RD;
            3'b100:  return sdbl_pkg::CMD_WR;
            3'b010:  return sdbl_pkg::CMD_PRE;
            3'b001:  return sdbl_pkg::CMD_REF;
            3'b000:  return sdbl_pkg::CMD_MRS;
            default: return sdbl_pkg::CMD_BST;
        endcase
    endfunction : sdbl_decode

    // bank state may be closed by a precharge-all
    function automatic logic sdbl_closable(input sdbl_pkg::sdbl_bank_st_t s);
        return (s == sdbl_pkg::BK_IDLE) || (s == sdbl_pkg::BK_ACTV)
            || (s == sdbl_pkg::BK_RD) || (s == sdbl_pkg::BK_WR);
    endfunction : sdbl_closable

    logic [sdbl_pkg::PIN_W-1:0]     pin_s1_r;
    logic [sdbl_pkg::PIN_W-1:0]     pin_s2_r;
    logic                           cke_prev_r;

    sdbl_pkg::sdbl_glob_st_t        glob_r;
    sdbl_pkg::sdbl_glob_st_t        glob_nxt;
    logic [sdbl_pkg::TMR_W-1:0]     gtmr_r;
    logic [sdbl_pkg::TMR_W-1:0]     gtmr_nxt;

    logic [1:0]                     last_bk_r;
    logic [1:0]                     last_bk_nxt;

    logic                           all_idle_r;
    logic                           busy_r;
    logic                           sref_r;
    logic                           accept_r;
    logic                           illegal_r;
    logic [3:0]                     cmd_r;

    wire                            cke_s;
    wire                            cs_n_s;
    wire                            ras_n_s;
    wire                            cas_n_s;
    wire                            we_n_s;
    wire  [1:0]                     bk_s;
    wire                            a10_s;

    sdbl_pkg::sdbl_cmd_t            cmd_d;

    wire                            cke_run;
    wire                            cke_enter_low;
    wire                            cke_wake;
    wire                            is_nop;
    wire                            norm;

    wire                            all_idle;
    wire                            all_closable;
    wire                            pre_all;
    wire                            tgt_ok;
    wire                            burst_cmd;

    logic                           legal;
    wire                            take;
    wire                            flag_bad;
    wire                            gdone;

    wire  [sdbl_pkg::NUM_BANKS-1:0] idle_v;
    wire  [sdbl_pkg::NUM_BANKS-1:0] clos_v;
    wire  [sdbl_pkg::NUM_BANKS-1:0] ok_v;
    wire  [sdbl_pkg::NUM_BANKS-1:0] rw_v;

    // pins from the controller pass two flip-flops before use
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_s1_r <= sdbl_pkg::PIN_RST;
            pin_s2_r <= sdbl_pkg::PIN_RST;
        end else begin
            pin_s1_r <= {a10_i, bank_i, we_n_i, cas_n_i, ras_n_i, cs_n_i, cke_i};
            pin_s2_r <= pin_s1_r;
        end
    end

    assign cke_s   = pin_s2_r[0];
    assign cs_n_s  = pin_s2_r[1];
    assign ras_n_s = pin_s2_r[2];
    assign cas_n_s = pin_s2_r[3];
    assign we_n_s  = pin_s2_r[4];
    assign bk_s    = pin_s2_r[6:5];
    assign a10_s   = pin_s2_r[7];

    assign cmd_d         = sdbl_decode(cs_n_s, ras_n_s, cas_n_s, we_n_s);
    assign is_nop        = (cmd_d == sdbl_pkg::CMD_INHIBIT) || (cmd_d == sdbl_pkg::CMD_NOP);
    assign cke_run       = cke_prev_r && cke_s;
    assign cke_enter_low = cke_prev_r && !cke_s;
    assign cke_wake      = !cke_prev_r && cke_s;
    assign norm          = (glob_r == sdbl_pkg::G_NORM);
    assign gdone         = (gtmr_r == sdbl_pkg::TMR_W'(1));

    sdbl_bank_if bif [sdbl_pkg::NUM_BANKS] ();

    genvar gi;
    generate
        for (gi = 0; gi < sdbl_pkg::NUM_BANKS; gi++) begin : g_bank
            assign idle_v[gi] = (bif[gi].st == sdbl_pkg::BK_IDLE);
            assign clos_v[gi] = sdbl_closable(bif[gi].st);
            assign ok_v[gi]   = bif[gi].same_ok;
            assign rw_v[gi]   = (bif[gi].st == sdbl_pkg::BK_RD) || (bif[gi].st == sdbl_pkg::BK_WR);

            // each bank sees the command; only its own state judges it
            assign bif[gi].cmd    = cmd_d;
            assign bif[gi].ap     = a10_s;
            assign bif[gi].cmd_go = take && ((cmd_d == sdbl_pkg::CMD_PRE && pre_all)
                                    || (cmd_d != sdbl_pkg::CMD_BST && bk_s == 2'(gi)));
            assign bif[gi].stop   = take && (cmd_d == sdbl_pkg::CMD_BST) && (last_bk_r == 2'(gi));
            assign bif[gi].cut    = take && burst_cmd && (bk_s != 2'(gi));

            sdbl_bank #(
                .BURST_LEN (BURST_LEN)
            ) u_bank (
                .clk_i     (clk_i),
                .sys_rst_i (sys_rst_i),
                .bif       (bif[gi])
            );

            assign bank_state_o[gi*8 +: 8] = bif[gi].st;
        end
    endgenerate

    assign all_idle     = &idle_v;
    assign all_closable = &clos_v;
    assign pre_all      = (cmd_d == sdbl_pkg::CMD_PRE) && a10_s;
    assign tgt_ok       = ok_v[bk_s];
    assign burst_cmd    = (cmd_d == sdbl_pkg::CMD_RD) || (cmd_d == sdbl_pkg::CMD_WR);

    // legality of a non-nop command in normal operation
    always_comb begin
        unique case (cmd_d)
            sdbl_pkg::CMD_ACT,
            sdbl_pkg::CMD_RD,
            sdbl_pkg::CMD_WR:  legal = tgt_ok;
            sdbl_pkg::CMD_PRE: legal = a10_s ? all_closable : tgt_ok;
            sdbl_pkg::CMD_REF,
            sdbl_pkg::CMD_MRS: legal = all_idle;
            sdbl_pkg::CMD_BST: legal = rw_v[last_bk_r];
            default:           legal = 1'b1;
        endcase
    end

    assign take     = cke_run && norm && !is_nop && legal;
    assign flag_bad = cke_run && !is_nop && !(norm && legal);

    // global refresh, mode load and self refresh sequencing
    always_comb begin
        glob_nxt = glob_r;
        gtmr_nxt = (gtmr_r > sdbl_pkg::TMR_W'(1)) ? gtmr_r - sdbl_pkg::TMR_W'(1) : gtmr_r;
        unique case (glob_r)
            sdbl_pkg::G_NORM: begin
                if (cke_enter_low && cmd_d == sdbl_pkg::CMD_REF && all_idle) begin
                    glob_nxt = sdbl_pkg::G_SREF;
                end else if (take && cmd_d == sdbl_pkg::CMD_REF) begin
                    glob_nxt = sdbl_pkg::G_REF;
                    gtmr_nxt = REF_T;
                end else if (take && cmd_d == sdbl_pkg::CMD_MRS) begin
                    glob_nxt = sdbl_pkg::G_MRS;
                    gtmr_nxt = MRS_T;
                end
            end
            sdbl_pkg::G_REF,
            sdbl_pkg::G_MRS: begin
                if (gdone) begin
                    glob_nxt = sdbl_pkg::G_NORM;
                end
            end
            sdbl_pkg::G_SREF: begin
                if (cke_wake) begin
                    glob_nxt = sdbl_pkg::G_SXIT;
                    gtmr_nxt = SXIT_T;
                end
            end
            sdbl_pkg::G_SXIT: begin
                if (gdone) begin
                    glob_nxt = sdbl_pkg::G_NORM;
                end
            end
            default: begin
                glob_nxt = sdbl_pkg::G_NORM;
            end
        endcase
    end

    assign last_bk_nxt = (take && burst_cmd) ? bk_s : last_bk_r;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cke_prev_r <= 1'b0;
            glob_r     <= sdbl_pkg::G_NORM;
            gtmr_r     <= '0;
            last_bk_r  <= 2'h0;
        end else begin
            cke_prev_r <= cke_s;
            glob_r     <= glob_nxt;
            gtmr_r     <= gtmr_nxt;
            last_bk_r  <= last_bk_nxt;
        end
    end

    // registered status outputs
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            all_idle_r <= 1'b1;
            busy_r     <= 1'b0;
            sref_r     <= 1'b0;
            accept_r   <= 1'b0;
            illegal_r  <= 1'b0;
            cmd_r      <= 4'h0;
        end else begin
            all_idle_r <= all_idle && norm;
            busy_r     <= !norm;
            sref_r     <= (glob_r == sdbl_pkg::G_SREF) || (glob_r == sdbl_pkg::G_SXIT);
            accept_r   <= take;
            illegal_r  <= flag_bad;
            cmd_r      <= cmd_d;
        end
    end

    assign all_idle_o     = all_idle_r;
    assign busy_o         = busy_r;
    assign self_refresh_o = sref_r;
    assign accept_o       = accept_r;
    assign illegal_o      = illegal_r;
    assign cmd_o          = cmd_r;
endmodule : sdbl_top

// file: sdbl_ctrl_model.sv
// controller-side model that puts bench commands on the command pins
module sdbl_ctrl_model (
    input  wire sdbl_pkg::sdbl_cmd_t cmd_i,
    input  wire logic                clk_i,
    output logic                     cs_n_o,
    output logic [2:0]               rcw_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] junk_r = 3'h5;
    // strobes are not held while deselected
    always @(posedge clk_i) begin
        junk_r <= ~junk_r;
    end
    assign cs_n_o = (cmd_i == sdbl_pkg::CMD_INHIBIT);
    always_comb begin
        case (cmd_i)
            sdbl_pkg::CMD_NOP: rcw_o = 3'h7;
            sdbl_pkg::CMD_ACT: rcw_o = 3'h3;
            sdbl_pkg::CMD_RD:  rcw_o = 3'h5;
            sdbl_pkg::CMD_WR:  rcw_o = 3'h4;
            sdbl_pkg::CMD_PRE: rcw_o = 3'h2;
            sdbl_pkg::CMD_REF: rcw_o = 3'h1;
            sdbl_pkg::CMD_MRS: rcw_o = 3'h0;
            sdbl_pkg::CMD_BST: rcw_o = 3'h6;
            default:           rcw_o = junk_r;
        endcase
    end
endmodule : sdbl_ctrl_model

// file: sdbl_top_chk.sv
// concurrent checks on the ports of the bank legality block
module sdbl_top_chk #(
    parameter int BURST_LEN = sdbl_pkg::BURST_LEN_DEF
) (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        cke_i,
    input wire logic        cs_n_i,
    input wire logic        ras_n_i,
    input wire logic        cas_n_i,
    input wire logic        we_n_i,
    input wire logic [1:0]  bank_i,
    input wire logic        a10_i,
    input wire logic [31:0] bank_state_o,
    input wire logic        all_idle_o,
    input wire logic        busy_o,
    input wire logic        self_refresh_o,
    input wire logic        accept_o,
    input wire logic        illegal_o,
    input wire logic [3:0]  cmd_o
);
    logic [7:0] st0;
    logic       ap0;
    logic [7:0] ap_cnt_r;
    assign st0 = bank_state_o[7:0];
    assign ap0 = (st0 == sdbl_pkg::BK_RDAP) || (st0 == sdbl_pkg::BK_WRAP);
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !ap0) begin
            ap_cnt_r <= 8'h00;
        end else begin
            ap_cnt_r <= ap_cnt_r + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_close;
        st0 == sdbl_pkg::BK_PRE ##1 st0 == sdbl_pkg::BK_IDLE;
    endsequence
    sequence s_ref_busy;
        busy_o [*4] ##1 !busy_o;
    endsequence
    sequence s_mrs_busy;
        busy_o [*2] ##1 !busy_o;
    endsequence
    property p_onehot;
        $onehot(st0) && $onehot(bank_state_o[15:8]) && $onehot(bank_state_o[23:16]) && $onehot(bank_state_o[31:24]);
    endproperty
    a_onehot: assert property (p_onehot) else $error("bank state not one-hot");
    property p_excl;
        !(accept_o && illegal_o);
    endproperty
    a_excl: assert property (p_excl) else $error("accept and illegal together");
    property p_nop;
        (cmd_o == sdbl_pkg::CMD_NOP || cmd_o == sdbl_pkg::CMD_INHIBIT) |-> !illegal_o;
    endproperty
    a_nop: assert property (p_nop) else $error("nop flagged illegal");
    property p_idle_exit;
        st0 == sdbl_pkg::BK_IDLE ##1 st0 != sdbl_pkg::BK_IDLE |-> st0 inside {sdbl_pkg::BK_ACTG, sdbl_pkg::BK_PRE};
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle bank left by bad path");
    property p_act;
        st0 == sdbl_pkg::BK_ACTG |=> st0 == sdbl_pkg::BK_ACTV;
    endproperty
    a_act: assert property (p_act) else $error("activating not one cycle");
    property p_pre;
        st0 == sdbl_pkg::BK_PRE |=> st0 == sdbl_pkg::BK_IDLE;
    endproperty
    a_pre: assert property (p_pre) else $error("precharging not one cycle");
    property p_ap;
        ap0 && ap_cnt_r == 8'(BURST_LEN - 1) |=> s_close;
    endproperty
    a_ap: assert property (p_ap) else $error("autoclose did not close");
    property p_ref;
        accept_o && cmd_o == sdbl_pkg::CMD_REF |=> s_ref_busy;
    endproperty
    a_ref: assert property (p_ref) else $error("refresh busy length wrong");
    property p_mrs;
        accept_o && cmd_o == sdbl_pkg::CMD_MRS |=> s_mrs_busy;
    endproperty
    a_mrs: assert property (p_mrs) else $error("mode load busy length wrong");
endmodule : sdbl_top_chk
bind sdbl_top sdbl_top_chk #(.BURST_LEN(BURST_LEN)) u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cke_i(cke_i), .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
    .bank_i(bank_i), .a10_i(a10_i), .bank_state_o(bank_state_o), .all_idle_o(all_idle_o),
    .busy_o(busy_o), .self_refresh_o(self_refresh_o), .accept_o(accept_o),
    .illegal_o(illegal_o), .cmd_o(cmd_o));

// file: sdbl_top_test.sv
// self-checking bench for the bank legality block
module sdbl_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BL = 8;
    logic                clk_i     = 1'b0;
    logic                sys_rst_i = 1'b1;
    logic                cke_i     = 1'b0;
    sdbl_pkg::sdbl_cmd_t cmd       = sdbl_pkg::CMD_INHIBIT;
    logic [1:0]          bank      = 2'h0;
    logic                a10       = 1'b0;
    logic                cs_n;
    logic [2:0]          rcw;
    logic [31:0]         bst;
    logic                all_idle, busy, sref, acc, ill;
    logic [3:0]          cmd_o;
    int                  bad_count = 0;
    int                  n_checks  = 0;
    always #10 clk_i = ~clk_i;
    sdbl_ctrl_model u_ctl (.cmd_i(cmd), .clk_i(clk_i), .cs_n_o(cs_n), .rcw_o(rcw));
    sdbl_top #(.BURST_LEN(BL)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cke_i(cke_i),
        .cs_n_i(cs_n), .ras_n_i(rcw[2]), .cas_n_i(rcw[1]), .we_n_i(rcw[0]), .bank_i(bank),
        .a10_i(a10), .bank_state_o(bst), .all_idle_o(all_idle), .busy_o(busy),
        .self_refresh_o(sref), .accept_o(acc), .illegal_o(ill), .cmd_o(cmd_o));
    function automatic logic [7:0] st_of(logic [1:0] b);
        return bst[int'(b) * 8 +: 8];
    endfunction : st_of
    function automatic logic [7:0] exp_rw(logic w, logic a);
        if (a) return w ? sdbl_pkg::BK_WRAP : sdbl_pkg::BK_RDAP;
        return w ? sdbl_pkg::BK_WR : sdbl_pkg::BK_RD;
    endfunction : exp_rw
    function automatic logic exp_acc_idle(sdbl_pkg::sdbl_cmd_t c);
        return c inside {sdbl_pkg::CMD_REF, sdbl_pkg::CMD_MRS, sdbl_pkg::CMD_PRE};
    endfunction : exp_acc_idle
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    task automatic chk_flag(string nm, logic e, logic s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %0h got %0h", nm, e, s);
        end
    endtask : chk_flag
    task automatic chk_st(string nm, logic [7:0] e, logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %0h got %0h", nm, e, s);
        end
    endtask : chk_st
    task automatic chk_cmd(string nm, logic [3:0] e, logic [3:0] s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %0h got %0h", nm, e, s);
        end
    endtask : chk_cmd
    // drive one command for one edge, return where its answer stands
    task automatic issue_chk(sdbl_pkg::sdbl_cmd_t c, logic [1:0] b, logic a, logic e_acc);
        cmd = c;
        bank = b;
        a10 = a;
        @(posedge clk_i);
        #1;
        cmd = sdbl_pkg::CMD_INHIBIT;
        bank = ~b;
        a10 = ~a;
        repeat (2) @(posedge clk_i);
        #1;
        chk_cmd("cmd", c, cmd_o);
        if (c > sdbl_pkg::CMD_NOP) chk_flag("accept", e_acc, acc);
        chk_flag("illegal", !e_acc && c > sdbl_pkg::CMD_NOP && cke_i, ill);
    endtask : issue_chk
    task automatic wait_idle(logic [1:0] b);
        int k = 0;
        do begin
            @(posedge clk_i);
            #1;
            k++;
        end while ((st_of(b) !== sdbl_pkg::BK_IDLE || busy !== 1'b0) && k < 40);
        if (k == 40) begin
            bad_count++;
            $display("BAD wait_idle exp 1 got 0");
            end_sim();
        end
    endtask : wait_idle
    sdbl_pkg::sdbl_cmd_t tbl [8] = '{sdbl_pkg::CMD_INHIBIT, sdbl_pkg::CMD_NOP, sdbl_pkg::CMD_REF,
        sdbl_pkg::CMD_MRS, sdbl_pkg::CMD_BST, sdbl_pkg::CMD_PRE, sdbl_pkg::CMD_RD, sdbl_pkg::CMD_WR};
    initial begin
        logic [1:0] b;
        logic       w, a;
        void'($urandom(51));
        repeat (6) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        for (int i = 0; i < 4; i++) chk_st("reset", sdbl_pkg::BK_IDLE, st_of(2'(i)));
        chk_flag("all_idle", 1'b1, all_idle);
        cke_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            issue_chk(tbl[i], 2'h0, 1'b0, exp_acc_idle(tbl[i]));
            chk_st("idle", sdbl_pkg::BK_IDLE, st_of(2'h0));
            wait_idle(2'h0);
        end
        $display("test decode done");
        for (int n = 0; n < 10; n++) begin
            b = (n < 4) ? 2'h0 : 2'($urandom % 4);
            w = (n < 4) ? n[1] : 1'($urandom % 2);
            a = (n < 4) ? n[0] : 1'($urandom % 2);
            issue_chk(sdbl_pkg::CMD_ACT, b, 1'b0, 1'b1);
            chk_st("act", sdbl_pkg::BK_ACTG, st_of(b));
            chk_st("other", sdbl_pkg::BK_IDLE, st_of(2'(b + 2'h1)));
            issue_chk(w ? sdbl_pkg::CMD_WR : sdbl_pkg::CMD_RD, b, a, 1'b1);
            chk_st("burst", exp_rw(w, a), st_of(b));
            if (!a) begin
                issue_chk(sdbl_pkg::CMD_BST, ~b, 1'b0, 1'b1);
                chk_st("bst", sdbl_pkg::BK_ACTV, st_of(b));
                issue_chk(sdbl_pkg::CMD_PRE, b, 1'b0, 1'b1);
                chk_st("pre", sdbl_pkg::BK_PRE, st_of(b));
            end
            wait_idle(b);
        end
        $display("test random bursts done");
        issue_chk(sdbl_pkg::CMD_ACT, 2'h0, 1'b0, 1'b1);
        issue_chk(sdbl_pkg::CMD_ACT, 2'h1, 1'b0, 1'b1);
        issue_chk(sdbl_pkg::CMD_RD, 2'h0, 1'b1, 1'b1);
        issue_chk(sdbl_pkg::CMD_WR, 2'h1, 1'b0, 1'b1);
        chk_st("interrupted", sdbl_pkg::BK_PRE, st_of(2'h0));
        chk_st("wr1", sdbl_pkg::BK_WR, st_of(2'h1));
        issue_chk(sdbl_pkg::CMD_RD, 2'h1, 1'b0, 1'b1);
        chk_st("rd1", sdbl_pkg::BK_RD, st_of(2'h1));
        issue_chk(sdbl_pkg::CMD_REF, 2'h0, 1'b0, 1'b0);
        issue_chk(sdbl_pkg::CMD_PRE, 2'h0, 1'b1, 1'b1);
        chk_st("preall", sdbl_pkg::BK_PRE, st_of(2'h1));
        wait_idle(2'h1);
        @(posedge clk_i);
        #1;
        chk_flag("all_idle", 1'b1, all_idle);
        $display("test two banks done");
        cke_i = 1'b0;
        issue_chk(sdbl_pkg::CMD_REF, 2'h0, 1'b0, 1'b0);
        issue_chk(sdbl_pkg::CMD_ACT, 2'h3, 1'b0, 1'b0);
        chk_st("ignored", sdbl_pkg::BK_IDLE, st_of(2'h3));
        chk_flag("sref", 1'b1, sref);
        cke_i = 1'b1;
        wait_idle(2'h3);
        chk_flag("sref", 1'b0, sref);
        $display("test clock enable done");
        end_sim();
    end
endmodule : sdbl_top_test
